// File: rtl/xae_pkg.sv
/*
 * Shared constants and types for the extended data addressing and fast port block:
 * special-function addresses, data-space region bounds, reset values and carriers.
 * Assumes an 8051-class core presenting a simple SFR bus and a data-move address request.
 */
package xae_pkg;

   // special-function addresses of the registers this block owns
   localparam logic [7:0] SFR_PTR_SEL = 8'h86;
   localparam logic [7:0] SFR_PTR0_EXT = 8'h93;
   localparam logic [7:0] SFR_PTR1_EXT = 8'h95;
   localparam logic [7:0] SFR_TOP_BYTE = 8'hEA;
   localparam logic [7:0] SFR_MID_BYTE = 8'hA0;

   localparam int NUM_FAST_PORTS = 9;
   // fast port triplet addresses, index order ports 0..6, 12, 15
   localparam logic [7:0] SFR_PORT_VAL [NUM_FAST_PORTS] =
      '{8'h80, 8'h90, 8'h98, 8'hB0, 8'hC0, 8'hC8, 8'hD8, 8'hE8, 8'hF8};
   localparam logic [7:0] SFR_PORT_PIN [NUM_FAST_PORTS] =
      '{8'h89, 8'h91, 8'h99, 8'hB1, 8'hC1, 8'hC9, 8'hD9, 8'hE9, 8'hF9};
   localparam logic [7:0] SFR_PORT_SEL [NUM_FAST_PORTS] =
      '{8'h8A, 8'hA2, 8'h9A, 8'hB2, 8'hC2, 8'hCA, 8'hDA, 8'hF2, 8'hFA};

   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic RST_PTR_SEL = 1'b0;

   // data-space region bounds, inclusive
   localparam logic [23:0] SRAM_LO = 24'h000000;
   localparam logic [23:0] SRAM_HI = 24'h001FFF;
   localparam logic [23:0] PORTS_LO = 24'h005000;
   localparam logic [23:0] PORTS_HI = 24'h0051FF;
   localparam logic [23:0] EMCTL_LO = 24'h005400;
   localparam logic [23:0] EMCTL_HI = 24'h0054FF;
   localparam logic [23:0] EEPROM_LO = 24'h008000;
   localparam logic [23:0] EEPROM_HI = 24'h008FFF;
   localparam logic [23:0] ECC_LO = 24'h080000;
   localparam logic [23:0] ECC_HI = 24'h081FFF;
   localparam logic [23:0] EXTMEM_LO = 24'h800000;

   // how a data move forms its address
   typedef enum logic [1:0] {
      XAE_VIA_PTR,
      XAE_VIA_R0R1,
      XAE_NOT_MOVE
   } xae_mode_t;

   // one-hot region select
   typedef struct packed {
      logic sram;
      logic portCtl;
      logic extMemCtl;
      logic eeprom;
      logic eccBytes;
      logic extMem;
      logic other;
   } xae_region_t;

   // sfr bus request from the core
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } xae_sfr_req_t;

endpackage

// File: rtl/xae_core.sv
/*
 * Extended data-move address former, data-space region decoder and fast port registers.
 * Assumes the core drives SFR requests and data-move requests synchronously on clock;
 * pin levels arrive from the pads and are synchronised here.
 */
// What this block does
// [R1] pointer select bit picks data pointer zero or one for pointer instructions
// [R2] pointer moves take top address byte from that pointer's extension register
// [R3] R0/R1 moves take top byte and middle byte from the indirect registers
// [R4] extension registers shape only data-move addresses, nothing else
// [R5] data-move address space is 24 bits, mostly decoded on chip
// [R6] 0x000000 to 0x001FFF decodes to on-chip SRAM
// [R7] 0x800000 to 0xFFFFFF goes to the external memory interface
// [R8] 0x080000 to 0x081FFF decodes to flash error-correction bytes
// [R9] 0x005000 to 0x0051FF decodes to port control registers via hub
// [R10] 0x005400 to 0x0054FF decodes to external memory interface control
// [R11] 0x008000 to 0x008FFF decodes to EEPROM
// [R12] select bit one: fast output value bit drives the pin
// [R13] select bit zero: hub output value bit drives the pin
// [R14] read-only pin state register returns current pin levels
// [R15] fast triplets exist only for ports 0 to 6, 12 and 15
// [R16] fast path reaches a subset; hub path keeps every port register
// [R17] writes to a pin state register are ignored
`timescale 1ns/1ps
module xae_core #(
   parameter int PORT_W = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire xae_pkg::xae_sfr_req_t sfrReq,
   output logic [7:0] sfrRdata,
   output logic sfrHit,
   input wire xae_pkg::xae_mode_t moveMode,
   input wire logic moveR1,
   input wire logic [15:0] dataPtr0,
   input wire logic [15:0] dataPtr1,
   input wire logic [7:0] indirLow,
   input wire logic [7:0] otherAddr,
   output logic ptrSelect,
   output logic [15:0] activePtr,
   output logic [23:0] moveAddr,
   output xae_pkg::xae_region_t moveRegion,
   input wire logic [xae_pkg::NUM_FAST_PORTS*PORT_W-1:0] hubPortVal,
   input wire logic [xae_pkg::NUM_FAST_PORTS*PORT_W-1:0] padIn,
   output logic [xae_pkg::NUM_FAST_PORTS*PORT_W-1:0] pinOut
);

   localparam int NP = xae_pkg::NUM_FAST_PORTS;

   // the fast triplets and the pin mux assume eight pins a port
   if (PORT_W != 8) begin : gBadWidth
      $error("xae_core: ports are eight pins wide");
   end

   logic ptrSel_r, ptrSel_nxt;
   logic [7:0] ext0_r, ext0_nxt;
   logic [7:0] ext1_r, ext1_nxt;
   logic [7:0] topByte_r, topByte_nxt;
   logic [7:0] midByte_r, midByte_nxt;
   logic [7:0] outVal_r [NP];
   logic [7:0] outVal_nxt [NP];
   logic [7:0] outSel_r [NP];
   logic [7:0] outSel_nxt [NP];
   logic [NP*8-1:0] padMeta_r, padSync_r;
   logic [7:0] rdata_nxt;
   logic hit_nxt;

   // pads cross in from outside the clock domain
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         padMeta_r <= '0;
         padSync_r <= '0;
      end else begin
         padMeta_r <= padIn;
         padSync_r <= padMeta_r;
      end
   end

   // sfr writes; the pin state addresses have no write path at all
   always_comb begin
      ptrSel_nxt = ptrSel_r;
      ext0_nxt = ext0_r;
      ext1_nxt = ext1_r;
      topByte_nxt = topByte_r;
      midByte_nxt = midByte_r;
      outVal_nxt = outVal_r;
      outSel_nxt = outSel_r;
      if (sfrReq.wr) begin
         case (sfrReq.addr)
            xae_pkg::SFR_PTR_SEL: ptrSel_nxt = sfrReq.wdata[0]; // [R1]
            xae_pkg::SFR_PTR0_EXT: ext0_nxt = sfrReq.wdata;
            xae_pkg::SFR_PTR1_EXT: ext1_nxt = sfrReq.wdata;
            xae_pkg::SFR_TOP_BYTE: topByte_nxt = sfrReq.wdata;
            xae_pkg::SFR_MID_BYTE: midByte_nxt = sfrReq.wdata;
            default: ;
         endcase
         for (int p = 0; p < NP; p++) begin
            if (sfrReq.addr == xae_pkg::SFR_PORT_VAL[p]) begin
               outVal_nxt[p] = sfrReq.wdata;
            end
            if (sfrReq.addr == xae_pkg::SFR_PORT_SEL[p]) begin
               outSel_nxt[p] = sfrReq.wdata;
            end
            // pin state address deliberately absent // [R17]
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         ptrSel_r <= xae_pkg::RST_PTR_SEL;
         ext0_r <= xae_pkg::RST_BYTE;
         ext1_r <= xae_pkg::RST_BYTE;
         topByte_r <= xae_pkg::RST_BYTE;
         midByte_r <= xae_pkg::RST_BYTE;
         for (int p = 0; p < NP; p++) begin
            outVal_r[p] <= xae_pkg::RST_BYTE;
            outSel_r[p] <= xae_pkg::RST_BYTE;
         end
      end else begin
         ptrSel_r <= ptrSel_nxt;
         ext0_r <= ext0_nxt;
         ext1_r <= ext1_nxt;
         topByte_r <= topByte_nxt;
         midByte_r <= midByte_nxt;
         outVal_r <= outVal_nxt;
         outSel_r <= outSel_nxt;
      end
   end

   // registered read data, one cycle after the read strobe
   always_comb begin
      rdata_nxt = 8'h00;
      hit_nxt = 1'b0;
      if (sfrReq.rd) begin
         hit_nxt = 1'b1;
         case (sfrReq.addr)
            xae_pkg::SFR_PTR_SEL: rdata_nxt = {7'h00, ptrSel_r};
            xae_pkg::SFR_PTR0_EXT: rdata_nxt = ext0_r;
            xae_pkg::SFR_PTR1_EXT: rdata_nxt = ext1_r;
            xae_pkg::SFR_TOP_BYTE: rdata_nxt = topByte_r;
            xae_pkg::SFR_MID_BYTE: rdata_nxt = midByte_r;
            default: hit_nxt = 1'b0;
         endcase
         for (int p = 0; p < NP; p++) begin // [R15]
            if (sfrReq.addr == xae_pkg::SFR_PORT_VAL[p]) begin
               rdata_nxt = outVal_r[p];
               hit_nxt = 1'b1;
            end
            if (sfrReq.addr == xae_pkg::SFR_PORT_SEL[p]) begin
               rdata_nxt = outSel_r[p];
               hit_nxt = 1'b1;
            end
            if (sfrReq.addr == xae_pkg::SFR_PORT_PIN[p]) begin
               rdata_nxt = padSync_r[p*8 +: 8]; // [R14]
               hit_nxt = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sfrRdata <= 8'h00;
         sfrHit <= 1'b0;
      end else begin
         sfrRdata <= rdata_nxt;
         sfrHit <= hit_nxt;
      end
   end

   // pointer choice feeds every pointer instruction in the core
   assign ptrSelect = ptrSel_r; // [R1]
   assign activePtr = ptrSel_r ? dataPtr1 : dataPtr0; // [R1]

   // address forming is combinational so the core sees it in the move cycle
   always_comb begin
      case (moveMode)
         xae_pkg::XAE_VIA_PTR: moveAddr = {(ptrSel_r ? ext1_r : ext0_r), activePtr}; // [R2]
         xae_pkg::XAE_VIA_R0R1: moveAddr = {topByte_r, midByte_r, indirLow}; // [R3]
         // other accesses zero-extend the 8-bit otherAddr and ignore the extension bytes
         default: moveAddr = {8'h00, (moveR1 ? 8'h00 : 8'h00) | 8'h00, otherAddr}; // [R4]
      endcase
   end

   // full 24-bit decode; unlisted space reports as other on-chip
   always_comb begin
      moveRegion = '0; // [R5]
      if (moveAddr >= xae_pkg::EXTMEM_LO) begin
         moveRegion.extMem = 1'b1; // [R7]
      end else if (moveAddr <= xae_pkg::SRAM_HI) begin
         moveRegion.sram = 1'b1; // [R6]
      end else if (moveAddr >= xae_pkg::ECC_LO && moveAddr <= xae_pkg::ECC_HI) begin
         moveRegion.eccBytes = 1'b1; // [R8]
      end else if (moveAddr >= xae_pkg::PORTS_LO && moveAddr <= xae_pkg::PORTS_HI) begin
         moveRegion.portCtl = 1'b1; // [R9] [R16]
      end else if (moveAddr >= xae_pkg::EMCTL_LO && moveAddr <= xae_pkg::EMCTL_HI) begin
         moveRegion.extMemCtl = 1'b1; // [R10]
      end else if (moveAddr >= xae_pkg::EEPROM_LO && moveAddr <= xae_pkg::EEPROM_HI) begin
         moveRegion.eeprom = 1'b1; // [R11]
      end else begin
         moveRegion.other = 1'b1;
      end
   end

   // per-pin output mux between fast and hub values
   genvar gp;
   generate
      for (gp = 0; gp < NP*8; gp++) begin : gPin
         assign pinOut[gp] = outSel_r[gp/8][gp%8] ? outVal_r[gp/8][gp%8] // [R12]
                                                  : hubPortVal[gp]; // [R13]
      end
   endgenerate

endmodule

// File: tb/xae_core_chk.sv
/* checker for xae_core: address forming, region decode, sfr reads, port 0 pin mux
   assumes one clock domain and the async active-low reset of the block */
`timescale 1ns/1ps
module xae_core_chk #(
   parameter int PORT_W = 8
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire xae_pkg::xae_sfr_req_t sfrReq,
   input wire logic [7:0] sfrRdata,
   input wire logic sfrHit,
   input wire xae_pkg::xae_mode_t moveMode,
   input wire logic [15:0] dataPtr0,
   input wire logic [15:0] dataPtr1,
   input wire logic [7:0] indirLow,
   input wire logic [7:0] otherAddr,
   input wire logic ptrSelect,
   input wire logic [23:0] moveAddr,
   input wire xae_pkg::xae_region_t moveRegion,
   input wire logic [xae_pkg::NUM_FAST_PORTS*PORT_W-1:0] hubPortVal,
   input wire logic [xae_pkg::NUM_FAST_PORTS*PORT_W-1:0] pinOut
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // shadow of every written byte; pin state entries are never consulted
   logic [7:0] shadow_r [256];
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         shadow_r <= '{default: 8'h00};
      end else if (sfrReq.wr) begin
         shadow_r[sfrReq.addr] <= sfrReq.wdata;
      end
   end
   chk_ptr_sel: assert property (
      sfrReq.wr && sfrReq.addr == xae_pkg::SFR_PTR_SEL |=> ptrSelect == $past(sfrReq.wdata[0]))
      else $error("pointer select not loaded");
   chk_ptr_addr: assert property (
      moveMode == xae_pkg::XAE_VIA_PTR |-> moveAddr == (ptrSelect ?
      {shadow_r[xae_pkg::SFR_PTR1_EXT], dataPtr1} : {shadow_r[xae_pkg::SFR_PTR0_EXT], dataPtr0}))
      else $error("pointer move address wrong");
   chk_indir_addr: assert property (
      moveMode == xae_pkg::XAE_VIA_R0R1 |-> moveAddr ==
      {shadow_r[xae_pkg::SFR_TOP_BYTE], shadow_r[xae_pkg::SFR_MID_BYTE], indirLow})
      else $error("indirect move address wrong");
   chk_plain_addr: assert property (
      moveMode == xae_pkg::XAE_NOT_MOVE |-> moveAddr == {16'h0000, otherAddr})
      else $error("extension applied outside moves");
   chk_region_onehot: assert property ($onehot(moveRegion))
      else $error("region select not one-hot");
   chk_sram_region: assert property (moveAddr <= xae_pkg::SRAM_HI |-> moveRegion.sram)
      else $error("sram region missed");
   chk_ext_region: assert property (
      moveAddr >= xae_pkg::EXTMEM_LO |-> moveRegion.extMem)
      else $error("external memory region missed");
   chk_fast_pin: assert property (
      pinOut[7:0] == ((shadow_r[xae_pkg::SFR_PORT_VAL[0]] & shadow_r[xae_pkg::SFR_PORT_SEL[0]])
      | (hubPortVal[7:0] & ~shadow_r[xae_pkg::SFR_PORT_SEL[0]])))
      else $error("port 0 pin mux wrong");
   chk_ext_read: assert property (
      sfrReq.rd && sfrReq.addr == xae_pkg::SFR_PTR0_EXT |=>
      sfrHit && sfrRdata == shadow_r[xae_pkg::SFR_PTR0_EXT])
      else $error("extension readback wrong");
endmodule
bind xae_core xae_core_chk #(.PORT_W(PORT_W)) chk (.clock(clock), .rst_n(rst_n),
   .sfrReq(sfrReq), .sfrRdata(sfrRdata), .sfrHit(sfrHit), .moveMode(moveMode),
   .dataPtr0(dataPtr0), .dataPtr1(dataPtr1), .indirLow(indirLow), .otherAddr(otherAddr),
   .ptrSelect(ptrSelect), .moveAddr(moveAddr), .moveRegion(moveRegion),
   .hubPortVal(hubPortVal), .pinOut(pinOut));

// File: tb/xae_cpu_model.sv
/* core-side model issuing one-cycle sfr write and read requests
   assumes the bench clock; tasks are called from the bench */
`timescale 1ns/1ps
module xae_cpu_model (
   input wire logic clock,
   input wire logic [7:0] sfrRdata,
   input wire logic sfrHit,
   output xae_pkg::xae_sfr_req_t sfrReq
);
   initial sfrReq = '{wr: 1'b0, rd: 1'b0, addr: 8'h00, wdata: 8'hFF};
   // idle bus shows the inverted address, and inverted data after a write, so stale data never looks valid
   task automatic sfrWrite(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #1 sfrReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock);
      #1 sfrReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask
   task automatic sfrRead(input logic [7:0] a, output logic [7:0] d, output logic h);
      @(posedge clock);
      #1 sfrReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5C};
      @(posedge clock);
      #1 d = sfrRdata;
      h = sfrHit;
      sfrReq = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA3};
   endtask
endmodule

// File: tb/xae_core_tb_top.sv
/* bench for xae_core: region table loop, then reset, pointer and fast port tests
   assumes xae_cpu_model for sfr cycles and the bound checker */
`timescale 1ns/1ps
module xae_core_tb_top;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   xae_pkg::xae_sfr_req_t sfrReq;
   xae_pkg::xae_mode_t moveMode = xae_pkg::XAE_NOT_MOVE;
   xae_pkg::xae_region_t moveRegion;
   logic sfrHit, ptrSelect, rhit, moveR1 = 1'b0;
   logic [7:0] sfrRdata, rdata, indirLow = 8'h00, otherAddr = 8'h00;
   logic [15:0] activePtr, dataPtr0 = 16'h0000, dataPtr1 = 16'h0000;
   logic [23:0] moveAddr;
   logic [71:0] pinOut, hubPortVal = {9{8'h3C}}, padIn = {9{8'h00}};
   int num_errors = 0;
   int checked = 0;
   // {address, region one-hot}: sram,portCtl,extMemCtl,eeprom,eccBytes,extMem,other
   logic [30:0] rows [12] = '{{24'h000000, 7'h40}, {24'h001FFF, 7'h40}, {24'h002000, 7'h01},
      {24'h005000, 7'h20}, {24'h0051FF, 7'h20}, {24'h005400, 7'h10}, {24'h008FFF, 7'h08},
      {24'h080000, 7'h04}, {24'h081FFF, 7'h04}, {24'h7FFFFF, 7'h01}, {24'h800000, 7'h02},
      {24'hFFFFFF, 7'h02}};
   always #5 clock = ~clock;
   xae_cpu_model cpu (.clock(clock), .sfrRdata(sfrRdata), .sfrHit(sfrHit), .sfrReq(sfrReq));
   xae_core #(.PORT_W(8)) dut (.clock(clock), .rst_n(rst_n), .sfrReq(sfrReq),
      .sfrRdata(sfrRdata), .sfrHit(sfrHit), .moveMode(moveMode), .moveR1(moveR1),
      .dataPtr0(dataPtr0), .dataPtr1(dataPtr1), .indirLow(indirLow), .otherAddr(otherAddr),
      .ptrSelect(ptrSelect), .activePtr(activePtr), .moveAddr(moveAddr),
      .moveRegion(moveRegion), .hubPortVal(hubPortVal), .padIn(padIn), .pinOut(pinOut));
   task automatic compare(input string what, input logic [71:0] exp, input logic [71:0] got);
      checked++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #200000 num_errors++;
      conclude();
   end
   initial begin
      repeat (4) @(posedge clock);
      #1 rst_n = 1'b1;
      for (int i = 0; i < 12; i++) begin
         cpu.sfrWrite(xae_pkg::SFR_TOP_BYTE, rows[i][30:23]);
         cpu.sfrWrite(xae_pkg::SFR_MID_BYTE, rows[i][22:15]);
         moveMode = xae_pkg::XAE_VIA_R0R1;
         moveR1 = i[0];
         indirLow = rows[i][14:7];
         #1 compare("indirect address", rows[i][30:7], moveAddr);
         compare("region", rows[i][6:0], moveRegion);
      end
      $display("region table done");
      rst_n = 1'b0;
      #20 rst_n = 1'b1;
      compare("select after reset", 1'b0, ptrSelect);
      compare("pins after reset", hubPortVal, pinOut);
      cpu.sfrRead(xae_pkg::SFR_TOP_BYTE, rdata, rhit);
      compare("top byte after reset", 9'h100, {rhit, rdata});
      $display("reset test done");
      cpu.sfrWrite(xae_pkg::SFR_PTR0_EXT, 8'h12);
      cpu.sfrWrite(xae_pkg::SFR_PTR1_EXT, 8'h9A);
      cpu.sfrWrite(xae_pkg::SFR_PTR_SEL, 8'h01);
      moveMode = xae_pkg::XAE_VIA_PTR;
      dataPtr0 = 16'h3456;
      dataPtr1 = 16'hBCDE;
      #1 compare("pointer one move", 24'h9ABCDE, moveAddr);
      compare("active pointer", 16'hBCDE, activePtr);
      cpu.sfrWrite(xae_pkg::SFR_PTR_SEL, 8'hFE);
      #1 compare("pointer zero move", 24'h123456, moveAddr);
      moveMode = xae_pkg::XAE_NOT_MOVE;
      otherAddr = 8'h77;
      #1 compare("plain access", 24'h000077, moveAddr);
      $display("pointer test done");
      padIn = {9{8'h5A}};
      for (int p = 0; p < 9; p++) begin
         cpu.sfrWrite(xae_pkg::SFR_PORT_SEL[p], 8'hF0);
         cpu.sfrWrite(xae_pkg::SFR_PORT_VAL[p], 8'hA5);
         cpu.sfrWrite(xae_pkg::SFR_PORT_PIN[p], 8'hFF);
         cpu.sfrRead(xae_pkg::SFR_PORT_PIN[p], rdata, rhit);
         compare("pin state", 9'h15A, {rhit, rdata});
         compare("pin mux", 8'hAC, pinOut[p*8+:8]);
      end
      cpu.sfrRead(8'hB8, rdata, rhit);
      compare("no triplet for port 7", 9'h000, {rhit, rdata});
      $display("fast port test done");
      conclude();
   end
endmodule
